//--- design/code_readback_host.sv
// Operation
// (R1) Read code memory four words per pass: table reads, then register shift-outs.
// (R2) Start by sending two jumps to 0x100 and one no-operation.
// (R3) Load top address byte to W0, then page register, then low bits pointer.
// (R4) Each pass clears write pointer, eight table reads each followed by two nops.
// (R5) Device packs four words into six registers with interleaved upper-byte pairs.
// (R6) Per register: move to visibility, nop, readout command 0001, then shift in.
// (R7) After each output phase send jump to 0x100 and a no-operation.
// (R8) Repeat passes until the requested number of words has been read.
// (R9) Executive region readback loops until exactly 736 words are retrieved.
// (R10) Keep at least 20 ns between command and operand, and operand and command.
// (R11) Wait at least 20 ns after readout command before first readout clock.
// (R12) Serial clock period at least 50 ns, low and high at least 20 ns.
// (R13) Hold off clocking at least 2 us after raising the programming voltage pin.
// (R14) Executive-assisted mode needs 10 us per command; this controller never uses it.
// (R15) Checksum is 16 bits: config sum plus code sum, or config alone if protected.
// (R16) Code sum adds all three bytes of every word read.
// (R17) Config sum adds bytes of seven config words each ANDed with its mask.
// (R18) With protection the general segment word is taken as 0x5.
// (R19) Segment words are zeroed before bulk erase; erase is not done here.
// (R20) Every command and operand is sent least significant bit first.
// (R21) Execute transfer is command 0000 followed by a 24-bit operand.
// (R22) Device drives 16 visibility bits LSB first, one per clock, then releases.
`include "readback_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module code_readback_host (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request
    input wire logic start,
    input wire logic [23:0] src_addr,
    input wire logic [15:0] word_count,
    input wire logic exec_region,
    input wire logic protect_on,
    // Configuration words for the checksum
    input wire logic [15:0] oscillator_config_word,
    input wire logic [15:0] watchdog_config_word,
    input wire logic [15:0] brownout_reset_config_word,
    input wire logic [15:0] boot_segment_config_word,
    input wire logic [15:0] secure_segment_config_word,
    input wire logic [15:0] general_segment_config_word,
    input wire logic [15:0] debug_config_word,
    // Result stream and status
    output logic busy,
    output logic done,
    output logic word_valid,
    output logic [23:0] word_data,
    output logic [15:0] checksum,
    // Device pins
    output logic reset_prog_voltage_pin,
    output logic prog_serial_clock,
    output logic prog_serial_data_o,
    output logic prog_serial_data_oe,
    input wire logic prog_serial_data_i
);

    localparam logic [23:0] RD_OPS [8] = '{`OP_RD_LOW_A, `OP_RD_HIGH_A, `OP_RD_HIGH_B,
        `OP_RD_LOW_B, `OP_RD_LOW_A, `OP_RD_HIGH_A, `OP_RD_HIGH_B, `OP_RD_LOW_LAST};

    readback_pkg::state_t state_ff;
    readback_pkg::step_t cur_step;
    logic [5:0] seq_ff;
    logic [1:0] phase_ff;
    logic [4:0] bit_ff;
    logic [4:0] bit_len;
    logic bit_last;
    logic [7:0] ent_ff;
    logic [3:0] gap_ff;
    logic gap_done;
    logic [1:0] emit_ff;
    logic [15:0] remain_ff;
    logic [15:0] rd_ff;
    logic [15:0] hold_ff [6];
    logic [2:0] out_idx;
    logic din_s1_ff;
    logic din_s2_ff;
    logic sclk_ff;
    logic sdo_ff;
    logic oe_ff;
    logic vpp_ff;
    logic done_ff;
    logic word_valid_ff;
    logic [23:0] word_ff;
    logic [15:0] code_sum_ff;
    logic [15:0] cfg_sum;
    logic [15:0] cfg_sum_ff;
    logic [15:0] checksum_ff;
    logic protect_ff;
    logic [23:0] emit_word;

    function automatic readback_pkg::step_t step_of(input logic [5:0] s, input logic [23:0] a);
        readback_pkg::step_t st;
        logic [5:0] k;
        logic [2:0] r;
        logic [1:0] m;
        st.is_read = 1'b0;
        st.cmd = `CMD_EXEC;
        st.op = `OP_NOP;
        k = 6'h00;
        r = 3'h0;
        m = 2'h0;
        // (R2) (R7) Jumps to 0x100.
        if (s < 6'd2 || s == `SEQ_GOTO) begin
            st.op = `OP_GOTO_100;
        // (R3) Source address load.
        end else if (s == `SEQ_ADDR_HI) begin
            st.op = `OP_MOV_LIT_W0 | {12'h000, a[23:16], 4'h0};
        end else if (s == `SEQ_PAGE) begin
            st.op = `OP_W0_TO_PAGE;
        end else if (s == `SEQ_ADDR_LO) begin
            st.op = `OP_MOV_LIT_W6 | {4'h0, a[15:0], 4'h0};
        // (R4) Clear write pointer.
        end else if (s == `SEQ_PASS) begin
            st.op = `OP_CLR_WPTR;
        // (R4) Eight table reads with two nops each.
        end else if (s >= `SEQ_READS && s < `SEQ_OUTS) begin
            k = s - `SEQ_READS;
            r = 3'(k / 6'd3);
            m = 2'(k % 6'd3);
            if (m == 2'd0) begin
                st.op = RD_OPS[r];
            end
        // (R6) Move to visibility, nop, readout command.
        end else if (s >= `SEQ_OUTS && s <= `SEQ_LAST_OUT) begin
            k = s - `SEQ_OUTS;
            r = 3'(k / 6'd3);
            m = 2'(k % 6'd3);
            if (m == 2'd0) begin
                st.op = `OP_MOV_VISIBILITY_REG | {21'h000000, r};
            end else if (m == 2'd2) begin
                st.cmd = `CMD_REGISTER_SHIFT_OUT_CMD;
                st.is_read = 1'b1;
            end
        end
        return st;
    endfunction : step_of

    always_comb begin
        cur_step = step_of(seq_ff, src_addr);
        out_idx = 3'((seq_ff - `SEQ_OUTS) / 6'd3);
        if (state_ff == readback_pkg::ST_CMD) begin
            bit_len = `CMD_BITS;
        end else if (cur_step.is_read) begin
            bit_len = `VISIBILITY_REG_BITS;
        end else begin
            bit_len = `OPER_BITS;
        end
        bit_last = (phase_ff == 2'(`BIT_PHASES - 1)) && (bit_ff == bit_len - 5'd1);
        gap_done = gap_ff == 4'(`GAP_CYC - 1);
    end

    // The first stage is read only by the second; the device drives the pin asynchronously.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            din_s1_ff <= 1'b0;
            din_s2_ff <= 1'b0;
        end else begin
            din_s1_ff <= prog_serial_data_i;
            din_s2_ff <= din_s1_ff;
        end
    end

    // (R1) Sequencing of passes.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= readback_pkg::ST_IDLE;
            seq_ff <= 6'h00;
        end else begin
            unique case (state_ff)
                readback_pkg::ST_IDLE: begin
                    if (start) begin
                        state_ff <= readback_pkg::ST_ENTRY;
                        seq_ff <= 6'h00;
                    end
                end
                // (R13) Entry hold-off.
                readback_pkg::ST_ENTRY: begin
                    if (ent_ff == 8'(`ENTRY_CYC - 1)) begin
                        state_ff <= readback_pkg::ST_CMD;
                    end
                end
                readback_pkg::ST_CMD: begin
                    if (bit_last) begin
                        state_ff <= readback_pkg::ST_GAP1;
                    end
                end
                // (R10) (R11) Gap before body.
                readback_pkg::ST_GAP1: begin
                    if (gap_done) begin
                        state_ff <= readback_pkg::ST_BODY;
                    end
                end
                // (R21) Operand body.
                readback_pkg::ST_BODY: begin
                    if (bit_last) begin
                        state_ff <= (seq_ff == `SEQ_LAST_OUT) ? readback_pkg::ST_EMIT
                                                             : readback_pkg::ST_GAP2;
                    end
                end
                readback_pkg::ST_EMIT: begin
                    if (emit_ff == 2'd3) begin
                        state_ff <= readback_pkg::ST_GAP2;
                    end
                end
                // (R8) Loop passes until the count is met.
                readback_pkg::ST_GAP2: begin
                    if (gap_done) begin
                        if (seq_ff != `SEQ_END) begin
                            seq_ff <= seq_ff + 6'd1;
                            state_ff <= readback_pkg::ST_CMD;
                        end else if (remain_ff == 16'h0000) begin
                            state_ff <= readback_pkg::ST_FINISH;
                        end else begin
                            seq_ff <= `SEQ_PASS;
                            state_ff <= readback_pkg::ST_CMD;
                        end
                    end
                end
                readback_pkg::ST_FINISH: begin
                    state_ff <= readback_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ent_ff <= 8'h00;
            gap_ff <= 4'h0;
        end else begin
            ent_ff <= (state_ff == readback_pkg::ST_ENTRY) ? ent_ff + 8'd1 : 8'h00;
            gap_ff <= (state_ff == readback_pkg::ST_GAP1 || state_ff == readback_pkg::ST_GAP2)
                      ? gap_ff + 4'd1 : 4'h0;
        end
    end

    // (R12) One high cycle then three low cycles per bit.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_ff <= 2'h0;
            bit_ff <= 5'h00;
        end else if (state_ff == readback_pkg::ST_CMD || state_ff == readback_pkg::ST_BODY) begin
            phase_ff <= phase_ff + 2'd1;
            if (phase_ff == 2'(`BIT_PHASES - 1)) begin
                bit_ff <= bit_last ? 5'h00 : bit_ff + 5'd1;
            end
        end else begin
            phase_ff <= 2'h0;
            bit_ff <= 5'h00;
        end
    end

    // Pins are registered so clock and data move together; the device samples on the fall.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_ff <= 1'b0;
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
            vpp_ff <= 1'b0;
        end else begin
            sclk_ff <= (state_ff == readback_pkg::ST_CMD || state_ff == readback_pkg::ST_BODY)
                       && phase_ff == 2'h0;
            // (R20) Bits leave least significant first.
            if (state_ff == readback_pkg::ST_CMD) begin
                sdo_ff <= cur_step.cmd[bit_ff[1:0]];
            end else if (state_ff == readback_pkg::ST_BODY && !cur_step.is_read) begin
                sdo_ff <= cur_step.op[bit_ff];
            end else begin
                sdo_ff <= 1'b0;
            end
            // (R22) Release the pin while the device shifts out.
            oe_ff <= state_ff != readback_pkg::ST_IDLE && state_ff != readback_pkg::ST_FINISH
                     && !(cur_step.is_read && (state_ff == readback_pkg::ST_BODY
                     || state_ff == readback_pkg::ST_EMIT || state_ff == readback_pkg::ST_GAP2));
            vpp_ff <= state_ff != readback_pkg::ST_IDLE && state_ff != readback_pkg::ST_FINISH;
        end
    end

    // (R22) Capture visibility bits, LSB first, three cycles after each rise.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_ff <= 16'h0000;
            for (int i = 0; i < 6; i++) begin
                hold_ff[i] <= 16'h0000;
            end
        end else if (state_ff == readback_pkg::ST_BODY && cur_step.is_read
                     && phase_ff == 2'(`BIT_PHASES - 1)) begin
            rd_ff <= {din_s2_ff, rd_ff[15:1]};
            if (bit_last) begin
                hold_ff[out_idx] <= {din_s2_ff, rd_ff[15:1]};
            end
        end
    end

    // (R5) Unpack six packed registers into four words.
    always_comb begin
        unique case (emit_ff)
            2'd0: emit_word = {hold_ff[1][7:0], hold_ff[0]};
            2'd1: emit_word = {hold_ff[1][15:8], hold_ff[2]};
            2'd2: emit_word = {hold_ff[4][7:0], hold_ff[3]};
            2'd3: emit_word = {hold_ff[4][15:8], hold_ff[5]};
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            emit_ff <= 2'h0;
            remain_ff <= 16'h0000;
            word_ff <= 24'h000000;
            word_valid_ff <= 1'b0;
            code_sum_ff <= 16'h0000;
        end else if (state_ff == readback_pkg::ST_IDLE && start) begin
            // (R9) Executive region count.
            remain_ff <= exec_region ? `EXEC_WORDS : word_count;
            code_sum_ff <= 16'h0000;
            word_valid_ff <= 1'b0;
        end else if (state_ff == readback_pkg::ST_EMIT) begin
            emit_ff <= emit_ff + 2'd1;
            word_ff <= emit_word;
            word_valid_ff <= remain_ff != 16'h0000;
            if (remain_ff != 16'h0000) begin
                remain_ff <= remain_ff - 16'd1;
                // (R16) Add all three bytes.
                code_sum_ff <= code_sum_ff + {8'h00, emit_word[23:16]}
                               + {8'h00, emit_word[15:8]} + {8'h00, emit_word[7:0]};
            end
        end else begin
            emit_ff <= 2'h0;
            word_valid_ff <= 1'b0;
        end
    end

    // (R17) Masked config byte sum.
    always_comb begin
        logic [15:0] w [7];
        w[0] = oscillator_config_word & `MASK_OSC;
        w[1] = watchdog_config_word & `MASK_WDT;
        w[2] = brownout_reset_config_word & `MASK_BOR;
        w[3] = boot_segment_config_word & `MASK_BOOT;
        w[4] = secure_segment_config_word & `MASK_SEC;
        // (R18) Protected general segment value.
        w[5] = (protect_on ? `GEN_PROTECTED : general_segment_config_word) & `MASK_GEN;
        w[6] = debug_config_word & `MASK_DBG;
        cfg_sum = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            cfg_sum = cfg_sum + {8'h00, w[i][15:8]} + {8'h00, w[i][7:0]};
        end
    end

    // (R15) Final checksum selection.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_sum_ff <= 16'h0000;
            protect_ff <= 1'b0;
            checksum_ff <= 16'h0000;
            done_ff <= 1'b0;
        end else begin
            if (state_ff == readback_pkg::ST_IDLE && start) begin
                cfg_sum_ff <= cfg_sum;
                protect_ff <= protect_on;
            end
            if (state_ff == readback_pkg::ST_FINISH) begin
                checksum_ff <= protect_ff ? cfg_sum_ff : cfg_sum_ff + code_sum_ff;
            end
            done_ff <= state_ff == readback_pkg::ST_FINISH;
        end
    end

    assign busy = state_ff != readback_pkg::ST_IDLE;
    assign done = done_ff;
    assign word_valid = word_valid_ff;
    assign word_data = word_ff;
    assign checksum = checksum_ff;
    assign reset_prog_voltage_pin = vpp_ff;
    assign prog_serial_clock = sclk_ff;
    assign prog_serial_data_o = sdo_ff;
    assign prog_serial_data_oe = oe_ff;

    logic [7:0] vpp_age_ff;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            vpp_age_ff <= 8'h00;
        end else if (!vpp_ff) begin
            vpp_age_ff <= 8'h00;
        end else if (vpp_age_ff != 8'hFF) begin
            vpp_age_ff <= vpp_age_ff + 8'd1;
        end
    end

    chk_entry_holdoff: assert property (@(posedge clk) disable iff (!resetn) // R13
        $rose(prog_serial_clock) |-> vpp_age_ff >= 8'(`ENTRY_CYC))
        else $error("serial clock started too soon after voltage raise");
    chk_clock_high_len: assert property (@(posedge clk) disable iff (!resetn) // R12
        $rose(prog_serial_clock) |=> !prog_serial_clock)
        else $error("serial clock high phase wrong");
    chk_clock_low_len: assert property (@(posedge clk) disable iff (!resetn) // R12
        $fell(prog_serial_clock) |-> !prog_serial_clock [*3])
        else $error("serial clock low phase too short");
    chk_cmd_oper_gap: assert property (@(posedge clk) disable iff (!resetn) // R10
        state_ff == readback_pkg::ST_GAP1 |=> !prog_serial_clock)
        else $error("no gap between command and operand");
    chk_readout_release: assert property (@(posedge clk) disable iff (!resetn) // R22
        (state_ff == readback_pkg::ST_BODY && cur_step.is_read) |=> !prog_serial_data_oe)
        else $error("host drives data during readout");
    chk_exit_reset: assert property (@(posedge clk) disable iff (!resetn) // R2
        $rose(busy) |-> seq_ff == 6'h00 ##1 cur_step.op == `OP_GOTO_100)
        else $error("readback did not start with jump");
    chk_pass_clear: assert property (@(posedge clk) disable iff (!resetn) // R4
        (state_ff == readback_pkg::ST_BODY && seq_ff == `SEQ_PASS) |-> cur_step.op == `OP_CLR_WPTR)
        else $error("pass did not clear write pointer");
    chk_goto_after: assert property (@(posedge clk) disable iff (!resetn) // R7
        (state_ff == readback_pkg::ST_EMIT && emit_ff == 2'd3) |=> ##1 seq_ff == `SEQ_GOTO)
        else $error("output phase not followed by jump");
    chk_register_shift_out_cmd_cmd: assert property (@(posedge clk) disable iff (!resetn) // R6
        (state_ff == readback_pkg::ST_BODY && cur_step.is_read) |-> cur_step.cmd == `CMD_REGISTER_SHIFT_OUT_CMD)
        else $error("readout without readout command");
    chk_sum_protected: assert property (@(posedge clk) disable iff (!resetn) // R15
        (done && protect_ff) |-> checksum == cfg_sum_ff)
        else $error("protected checksum includes code");
    chk_words_done: assert property (@(posedge clk) disable iff (!resetn) // R8
        $rose(done) |-> remain_ff == 16'h0000)
        else $error("finished before all words read");

    cov_word_out: cover property (@(posedge clk) disable iff (!resetn) word_valid);
    cov_two_passes: cover property (@(posedge clk) disable iff (!resetn)
        (state_ff == readback_pkg::ST_GAP2 && seq_ff == `SEQ_END && remain_ff != 16'h0000));
    cov_done_prot: cover property (@(posedge clk) disable iff (!resetn) done && protect_ff);

endmodule : code_readback_host

`default_nettype wire

//--- pkg/readback_defs.svh
`ifndef READBACK_DEFS_SVH
`define READBACK_DEFS_SVH

`define CLK_PERIOD_NS 40
`define T_ENTRY_HOLD_NS 2000
`define ENTRY_CYC ((`T_ENTRY_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_GAP_NS 20
`define GAP_CYC ((`T_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_PHASES 4
`define CMD_BITS 5'd4
`define OPER_BITS 5'd24
`define VISIBILITY_REG_BITS 5'd16

`define CMD_EXEC 4'h0
`define CMD_REGISTER_SHIFT_OUT_CMD 4'h1
`define OP_GOTO_100 24'h040100
`define OP_NOP 24'h000000
`define OP_MOV_LIT_W0 24'h200000
`define OP_MOV_LIT_W6 24'h200006
`define OP_W0_TO_PAGE 24'h880190
`define OP_CLR_WPTR 24'hEB0380
`define OP_MOV_VISIBILITY_REG 24'h883C20
`define OP_RD_LOW_A 24'hBA1B96
`define OP_RD_HIGH_A 24'hBADBB6
`define OP_RD_HIGH_B 24'hBADBD6
`define OP_RD_LOW_B 24'hBA1BB6
`define OP_RD_LOW_LAST 24'hBA0BB6

`define SEQ_ADDR_HI 6'd3
`define SEQ_PAGE 6'd4
`define SEQ_ADDR_LO 6'd5
`define SEQ_PASS 6'd6
`define SEQ_READS 6'd8
`define SEQ_OUTS 6'd32
`define SEQ_LAST_OUT 6'd49
`define SEQ_GOTO 6'd50
`define SEQ_END 6'd51

`define EXEC_WORDS 16'd736
`define MASK_OSC 16'hC10F
`define MASK_WDT 16'h803F
`define MASK_BOR 16'h87B3
`define MASK_BOOT 16'h310F
`define MASK_SEC 16'h330F
`define MASK_GEN 16'h0007
`define MASK_DBG 16'hC003
`define GEN_PROTECTED 16'h0005

`endif

//--- pkg/readback_pkg.sv
package readback_pkg;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ENTRY, ST_CMD, ST_GAP1, ST_BODY, ST_GAP2, ST_EMIT, ST_FINISH
    } state_t;

    typedef struct packed {
        logic is_read;
        logic [3:0] cmd;
        logic [23:0] op;
    } step_t;

endpackage : readback_pkg

//--- dv/prog_device_model.sv
`timescale 1ns/1ps
`default_nettype none

module prog_device_model (
    // Device pins
    input wire logic reset_prog_voltage_pin,
    input wire logic prog_serial_clock,
    input wire logic prog_serial_data,
    // Device drive and timing status
    output logic data_drive,
    output logic data_oe,
    output int n_viol
);
    logic [27:0] sh;
    logic [7:0] rb [0:11];
    logic [15:0] w6, visibility_reg;
    logic [7:0] page;
    int nb = 0, rd = 0, w7 = 0;
    time t_vpp = 0, t_rise = 0, t_fall = 0;

    function automatic logic [23:0] mem(input logic [23:0] a);
        return {a[7:0] ^ 8'h5A, a[15:0] ^ {a[23:16], 8'hC3}};
    endfunction : mem

    task automatic exec(input logic [23:0] op);
        logic [23:0] m;
        if (op[23:20] == 4'h2 && op[3:0] == 4'h6) begin
            w6 = op[19:4];
        end else if (op[23:20] == 4'h2 && op[3:0] < 4'h6) begin
            {rb[2 * op[3:0] + 1], rb[2 * op[3:0]]} = op[19:4];
        end else if (op == 24'h880190) begin
            page = rb[0];
        end else if (op == 24'hEB0380) begin
            w7 = 0;
        end else if (op[23:4] == 20'h883C2) begin
            visibility_reg = {rb[2 * op[3:0] + 1], rb[2 * op[3:0]]};
        end else if (op[23:16] == 8'hBA) begin
            if (op[6:4] == 3'd5) w6 = w6 + 16'h0001;
            m = mem({page, w6[15:1], 1'b0});
            if (op[14]) begin
                rb[w7] = m[23:16];
                w7 = w7 + 1;
            end else begin
                {rb[w7 + 1], rb[w7]} = m[15:0];
                w7 = w7 + 2;
            end
            if (op[6:4] == 3'd3) w6 = w6 + (op[14] ? 16'h0001 : 16'h0002);
        end
    endtask : exec

    initial begin
        data_drive = 1'b0;
        data_oe = 1'b0;
        n_viol = 0;
    end

    always @(posedge reset_prog_voltage_pin) t_vpp = $time;

    always @(negedge reset_prog_voltage_pin) begin
        nb = 0;
        rd = 0;
        data_oe = 1'b0;
    end

    always @(posedge prog_serial_clock) begin
        if ($time - t_vpp < 2000 || $time - t_rise < 50 || $time - t_fall < 20) n_viol++;
        t_rise = $time;
        if (rd > 0) rd--;
        data_oe = (rd > 0);
        data_drive = (rd > 0) ? visibility_reg[16 - rd] : ~data_drive;
    end

    always @(negedge prog_serial_clock) begin
        if ($time - t_rise < 20) n_viol++;
        t_fall = $time;
        if (reset_prog_voltage_pin && rd == 0) begin
            sh = {prog_serial_data, sh[27:1]};
            nb++;
            if (nb == 4 && sh[27:24] == 4'h1) begin
                rd = 17;
                nb = 0;
            end else if (nb == 28) begin
                if (sh[3:0] == 4'h0) exec(sh[27:4]);
                nb = 0;
            end
        end
    end
endmodule : prog_device_model

`default_nettype wire

//--- dv/serial_code_memory_readback_test.sv
`timescale 1ns/1ps
`default_nettype none

module serial_code_memory_readback_test;
    logic clk, resetn, start, protect_on, busy, done, word_valid;
    logic vpp, sclk, host_d, host_oe, dev_d, dev_oe;
    logic [23:0] src_addr, word_data;
    logic [15:0] word_count, checksum, exp_sum;
    logic [15:0] cfg [0:6];
    logic [23:0] exp_q [$];
    int n_viol, n_mismatch = 0, n_tests = 0, seed = 44565, cyc = 0;

    code_readback_host u_code_readback_host (
        .clk(clk), .resetn(resetn), .start(start), .src_addr(src_addr),
        .word_count(word_count), .exec_region(1'b0), .protect_on(protect_on),
        .oscillator_config_word(cfg[0]), .watchdog_config_word(cfg[1]),
        .brownout_reset_config_word(cfg[2]), .boot_segment_config_word(cfg[3]),
        .secure_segment_config_word(cfg[4]), .general_segment_config_word(cfg[5]),
        .debug_config_word(cfg[6]), .busy(busy), .done(done), .word_valid(word_valid),
        .word_data(word_data), .checksum(checksum), .reset_prog_voltage_pin(vpp),
        .prog_serial_clock(sclk), .prog_serial_data_o(host_d), .prog_serial_data_oe(host_oe),
        .prog_serial_data_i(host_oe ? host_d : dev_d));

    prog_device_model u_prog_device_model (
        .reset_prog_voltage_pin(vpp), .prog_serial_clock(sclk),
        .prog_serial_data(host_oe ? host_d : dev_d), .data_drive(dev_d),
        .data_oe(dev_oe), .n_viol(n_viol));

    function automatic logic [23:0] mem(input logic [23:0] a);
        return {a[7:0] ^ 8'h5A, a[15:0] ^ {a[23:16], 8'hC3}};
    endfunction : mem

    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        n_tests++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : check

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic run(input int k);
        logic [31:0] r;
        logic [23:0] a;
        logic [15:0] m;
        logic [15:0] masks [0:6];
        masks = '{16'hC10F, 16'h803F, 16'h87B3, 16'h310F, 16'h330F, 16'h0007, 16'hC003};
        r = $random(seed);
        src_addr = {r[23:16], 1'b0, r[14:1], 1'b0};
        word_count = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0005 : {13'h0000, r[27:25]} + 16'h0001;
        protect_on = k[0];
        exp_sum = 16'h0000;
        for (int i = 0; i < 7; i++) begin
            cfg[i] = 16'($random(seed));
            m = (k[0] && i == 5) ? 16'h0005 : cfg[i] & masks[i];
            exp_sum += 16'(m[15:8]) + 16'(m[7:0]);
        end
        for (int i = 0; i < word_count; i++) begin
            a = mem(src_addr + 24'(2 * i));
            exp_q.push_back(a);
            if (!k[0]) exp_sum += 16'(a[23:16]) + 16'(a[15:8]) + 16'(a[7:0]);
        end
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        check(busy, 1'b1);
        repeat (300) @(negedge clk);
        // A start while busy must be ignored.
        start = 1'b1;
        word_count = ~word_count;
        @(negedge clk);
        start = 1'b0;
        for (int w = 0; w < 20000 && done !== 1'b1; w++) @(negedge clk);
        check(checksum, exp_sum);
        check(exp_q.size(), 0);
        check(busy, 1'b0);
        exp_q.delete();
        @(negedge clk);
    endtask : run

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_mismatch++;
            conclude();
        end
    end

    always @(negedge clk) begin
        if (word_valid === 1'b1) begin
            check(word_data, exp_q.size() > 0 ? exp_q.pop_front() : 24'hxxxxxx);
        end
        if (dev_oe === 1'b1) begin
            check(host_oe, 1'b0);
        end
    end

    initial begin
        resetn = 1'b0;
        start = 1'b0;
        protect_on = 1'b0;
        src_addr = 24'h000000;
        word_count = 16'h0000;
        foreach (cfg[i]) cfg[i] = 16'h0000;
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        for (int k = 0; k < 4; k++) run(k);
        check(n_viol, 0);
        conclude();
    end
endmodule : serial_code_memory_readback_test

`default_nettype wire
